/* ds3_ovh_pkg.sv */
package ds3_ovh_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [5:0] TX_FIFO_STATUS_OFS = 6'h1a;
  localparam logic [5:0] FRAME_ERR_CNT_OFS  = 6'h1b;
  localparam logic [5:0] FEAC_TX_OFS        = 6'h1c;
  localparam logic [5:0] INT_STATUS_OFS     = 6'h30;
  localparam logic [5:0] INT_ENABLE_OFS     = 6'h31;
  localparam logic [5:0] INT_CLEAR_OFS      = 6'h32;
  localparam logic [5:0] HIGH_BYTE_CAP_OFS  = 6'h3e;

  // Field positions
  localparam int FIFO_STATE_LSB = 1;
  localparam int START_DONE_BIT = 7;
  localparam int CONT_BIT       = 6;
  localparam int CODE_W         = 6;

  // Interrupt status bits
  localparam int IRQ_OVERFLOW   = 0;
  localparam int IRQ_UNDERFLOW  = 1;
  localparam int IRQ_FEAC_DONE  = 2;
  localparam int IRQ_CNT_SAT    = 3;
  localparam int IRQ_N          = 4;

  // Transmit FIFO state encodings
  localparam logic [1:0] FS_HALF_OR_MORE = 2'h0;
  localparam logic [1:0] FS_BELOW_HALF   = 2'h1;
  localparam logic [1:0] FS_OVERFLOW     = 2'h2;
  localparam logic [1:0] FS_UNDERFLOW    = 2'h3;

  localparam int         CNT_W        = 16;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam int         FEAC_REPEATS = 10;
  localparam int         FEAC_WORD_W  = 16;

  typedef struct packed {
    logic half_or_more;
    logic full;
    logic wr_attempt;
    logic ran_empty;
    logic end_of_message_flag;
  } tx_fifo_ev_s;

  typedef struct packed {
    logic f_err;
    logic m_err;
    logic los;
    logic oof;
  } line_err_s;

  // Zero, code bits in field order, zero, eight ones; bit 0 goes first
  function automatic logic [15:0] feac_word(input logic [5:0] code);
    feac_word = {8'hff, 1'b0, code, 1'b0};
  endfunction

endpackage

/* sat_err_counter.sv */
`timescale 1ns/1ps
module sat_err_counter #(
  parameter int W = ds3_ovh_pkg::CNT_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         narrow,
  input  wire logic [1:0]   inc,
  input  wire logic         clr,
  output logic      [W-1:0] count
);
  import ds3_ovh_pkg::*;

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic [W:0]   sum;
  logic [W-1:0] max_val;
  logic [W-1:0] base;

  assign max_val = narrow ? W'(8'hff) : {W{1'b1}};
  // A read clears, but errors of the read cycle are kept
  assign base    = clr ? '0 : cnt_ff;
  assign sum     = {1'b0, base} + {{(W-1){1'b0}}, inc};
  // Clamp only on an increment, so an idle or inhibited counter holds
  assign nxt_cnt = (inc == 2'h0) ? base :
                   (sum > {1'b0, max_val}) ? max_val : sum[W-1:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign count = cnt_ff;

endmodule

/* feac_sender.sv */
`timescale 1ns/1ps
module feac_sender (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       cont,
  input  wire logic [5:0] code,
  input  wire logic       stop,
  input  wire logic       slot,
  output logic            busy,
  output logic            tx_bit,
  output logic            done
);
  import ds3_ovh_pkg::*;

  logic [15:0] word_ff;
  logic [3:0]  idx_ff;
  logic [3:0]  rep_ff;
  logic        cont_ff;
  logic        stop_ff;
  logic        busy_ff;
  logic        bit_ff;
  logic        done_ff;
  wire         last_bit = (idx_ff == 4'hf);
  wire         last_rep = (rep_ff == 4'(FEAC_REPEATS - 1));
  wire         finish   = slot && busy_ff && last_bit &&
                          (stop_ff || (!cont_ff && last_rep));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_ff <= '0;
      idx_ff  <= '0;
      rep_ff  <= '0;
      cont_ff <= 1'b0;
      stop_ff <= 1'b0;
      busy_ff <= 1'b0;
      bit_ff  <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      done_ff <= finish;
      if (start && !busy_ff) begin
        // Private copy: later field writes leave the word alone
        word_ff <= feac_word(code);
        cont_ff <= cont;
        idx_ff  <= '0;
        rep_ff  <= '0;
        stop_ff <= 1'b0;
        busy_ff <= 1'b1;
      end else begin
        if (stop && busy_ff && cont_ff) begin
          stop_ff <= 1'b1;
        end
        if (slot) begin
          bit_ff <= busy_ff ? word_ff[idx_ff] : 1'b1;
          if (busy_ff) begin
            idx_ff <= idx_ff + 4'h1;
            if (last_bit) begin
              rep_ff <= last_rep ? rep_ff : rep_ff + 4'h1;
            end
            if (finish) begin
              busy_ff <= 1'b0;
            end
          end
        end
      end
    end
  end

  assign busy   = busy_ff;
  assign tx_bit = bit_ff;
  assign done   = done_ff;

  property p_feac_ten_end;
    @(posedge clk) disable iff (!rst_n)
      (slot && busy_ff && last_bit && !cont_ff && last_rep
       && !start) |=> !busy_ff;
  endproperty
  a_feac_ten_end: assert property (p_feac_ten_end)
    else $error("ten-times send did not end after tenth word");

  property p_feac_order;
    @(posedge clk) disable iff (!rst_n)
      (slot && busy_ff && !start && idx_ff == 4'h1) |=>
        tx_bit == $past(word_ff[1]);
  endproperty
  a_feac_order: assert property (p_feac_order)
    else $error("first code bit not sent in field order");

endmodule

/* ds3_overhead_status_regs.sv */
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// What this block does
// - Tx FIFO state reads 00 at half full or more, 01 below half.
// - Tx FIFO state reads 10 after a write into a full FIFO.
// - Tx FIFO state reads 11 on underflow without end-of-message flag.
// - Both FIFO state bits change together in one clock.
// - Count F and M bit errors since last read, saturating.
// - Error counter holds during loss of signal or out of frame.
// - Reading the error counter clears it.
// - Compat pin low: 16-bit counter, low byte at its own address.
// - 16-bit mode: low byte read captures high byte for later read.
// - Compat pin high: counter is 8 bits wide.
// - Writing bit 7 high starts FEAC word transmission.
// - Bit 7 falls to report FEAC transmission done.
// - Bit 6 picks continuous sending or exactly ten words.
// - Bits 5-0 carry the code, sent in field order.
// - Ten-times mode clears bit 7 after the tenth word.
// - Bit 7 high with bit 6 low ends continuous sending.
module ds3_overhead_status_regs (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [5:0]               addr,
  input  wire logic [7:0]               wr_data,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic      [7:0]               rd_data,
  output logic                          irq,
  input  wire ds3_ovh_pkg::tx_fifo_ev_s fifo_ev,
  input  wire ds3_ovh_pkg::line_err_s   line_err,
  input  wire logic                     legacy_compat_select_pin,
  input  wire logic                     c3_bit_slot,
  output logic                          feac_tx_bit
);
  import ds3_ovh_pkg::*;

  // Compat pin synchroniser
  logic compat_meta_ff;
  logic compat_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compat_meta_ff <= 1'b0;
      compat_ff      <= 1'b0;
    end else begin
      compat_meta_ff <= legacy_compat_select_pin;
      compat_ff      <= compat_meta_ff;
    end
  end

  // Address decode
  wire sel_fifo = (addr == TX_FIFO_STATUS_OFS);
  wire sel_cnt  = (addr == FRAME_ERR_CNT_OFS);
  wire sel_feac = (addr == FEAC_TX_OFS);
  wire sel_ists = (addr == INT_STATUS_OFS);
  wire sel_ien  = (addr == INT_ENABLE_OFS);
  wire sel_iclr = (addr == INT_CLEAR_OFS);
  wire sel_cap  = (addr == HIGH_BYTE_CAP_OFS);

  wire rd_fifo  = rd_en && sel_fifo;
  wire rd_cnt   = rd_en && sel_cnt;
  wire wr_feac  = wr_en && sel_feac;
  wire wr_ien   = wr_en && sel_ien;
  wire wr_iclr  = wr_en && sel_iclr;

  // Transmit FIFO state
  logic [1:0] fifo_state_ff;
  logic [1:0] nxt_fifo_state;
  logic [1:0] fifo_err_ff;
  logic [1:0] nxt_fifo_err;
  logic [1:0] level_code;

  wire ovf_ev = fifo_ev.wr_attempt && fifo_ev.full;
  wire udf_ev = fifo_ev.ran_empty &&
                !fifo_ev.end_of_message_flag;

  assign level_code = fifo_ev.half_or_more ?
                      FS_HALF_OR_MORE : FS_BELOW_HALF;

  // Error codes stay until read; a new event beats the read
  assign nxt_fifo_err = ovf_ev ? FS_OVERFLOW :
                        udf_ev ? FS_UNDERFLOW :
                        rd_fifo ? 2'h0 : fifo_err_ff;

  assign nxt_fifo_state = (nxt_fifo_err != 2'h0) ?
                          nxt_fifo_err : level_code;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_err_ff   <= 2'h0;
      fifo_state_ff <= FS_BELOW_HALF;
    end else begin
      fifo_err_ff   <= nxt_fifo_err;
      fifo_state_ff <= nxt_fifo_state;
    end
  end

  // Framing and multiframe bit error counter
  logic [CNT_W-1:0] err_count;
  logic [1:0]       err_inc;
  logic [7:0]       cap_ff;
  logic [7:0]       nxt_cap;
  wire              cnt_inhibit = line_err.los || line_err.oof;
  wire [CNT_W-1:0]  cnt_max = compat_ff ? CNT_W'(8'hff)
                                        : {CNT_W{1'b1}};

  assign err_inc = cnt_inhibit ? 2'h0 :
                   2'({1'b0, line_err.f_err} +
                      {1'b0, line_err.m_err});

  sat_err_counter #(
    .W (CNT_W)
  ) u_err_cnt (
    .clk    (clk),
    .rst_n  (rst_n),
    .narrow (compat_ff),
    .inc    (err_inc),
    .clr    (rd_cnt),
    .count  (err_count)
  );

  assign nxt_cap = (rd_cnt && !compat_ff) ?
                   err_count[15:8] : cap_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_ff <= RESET_BYTE;
    end else begin
      cap_ff <= nxt_cap;
    end
  end

  wire cnt_sat_ev = (err_inc != 2'h0) &&
                    ((err_count == cnt_max) ||
                     ({1'b0, err_count} + 17'(err_inc) >
                      {1'b0, cnt_max}));

  // Transmit FEAC register
  logic       feac_cont_ff;
  logic [5:0] feac_code_ff;
  logic       feac_busy;
  logic       feac_done;

  wire feac_cmd  = wr_feac && wr_data[START_DONE_BIT];
  wire feac_go   = feac_cmd && !feac_busy;
  wire feac_stop = feac_cmd && feac_busy &&
                   !wr_data[CONT_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feac_cont_ff <= 1'b0;
      feac_code_ff <= '0;
    end else if (wr_feac && !feac_busy) begin
      feac_cont_ff <= wr_data[CONT_BIT];
      feac_code_ff <= wr_data[CODE_W-1:0];
    end
  end

  // Code is only reloaded while idle, which covers stray new starts
  feac_sender u_feac (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (feac_go),
    .cont   (wr_data[CONT_BIT]),
    .code   (wr_data[CODE_W-1:0]),
    .stop   (feac_stop),
    .slot   (c3_bit_slot),
    .busy   (feac_busy),
    .tx_bit (feac_tx_bit),
    .done   (feac_done)
  );

  // Interrupt status, enable and clear
  logic [IRQ_N-1:0] int_sts_ff;
  logic [IRQ_N-1:0] nxt_int_sts;
  logic [IRQ_N-1:0] int_en_ff;
  logic [IRQ_N-1:0] int_set;
  logic [IRQ_N-1:0] int_clr;
  logic             irq_ff;

  assign int_set[IRQ_OVERFLOW]  = ovf_ev;
  assign int_set[IRQ_UNDERFLOW] = udf_ev;
  assign int_set[IRQ_FEAC_DONE] = feac_done;
  assign int_set[IRQ_CNT_SAT]   = cnt_sat_ev;

  assign int_clr     = wr_iclr ? wr_data[IRQ_N-1:0] : '0;
  assign nxt_int_sts = (int_sts_ff & ~int_clr) | int_set;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_sts_ff <= '0;
      int_en_ff  <= '0;
      irq_ff     <= 1'b0;
    end else begin
      int_sts_ff <= nxt_int_sts;
      irq_ff     <= |(nxt_int_sts & int_en_ff);
      if (wr_ien) begin
        int_en_ff <= wr_data[IRQ_N-1:0];
      end
    end
  end

  assign irq = irq_ff;

  // Read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  logic [7:0] rd_data_ff;

  assign rd_mux =
    sel_fifo ? 8'({fifo_state_ff, 1'b0}) :
    sel_cnt  ? err_count[7:0] :
    sel_feac ? {feac_busy, feac_cont_ff, feac_code_ff} :
    sel_ists ? 8'(int_sts_ff) :
    sel_ien  ? 8'(int_en_ff) :
    sel_cap  ? cap_ff :
    8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
    end else if (rd_en) begin
      rd_data_ff <= rd_mux;
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  assign rd_data = rd_data_ff;

  property p_fifo_half;
    @(posedge clk) disable iff (!rst_n)
      (!ovf_ev && !udf_ev && fifo_err_ff == 2'h0 &&
       fifo_ev.half_or_more) |=> fifo_state_ff == 2'h0;
  endproperty
  a_fifo_half: assert property (p_fifo_half)
    else $error("fifo state not 00 at half full");

  property p_fifo_low;
    @(posedge clk) disable iff (!rst_n)
      (!ovf_ev && !udf_ev && (fifo_err_ff == 2'h0 || rd_fifo) &&
       !fifo_ev.half_or_more) |=> fifo_state_ff == 2'h1;
  endproperty
  a_fifo_low: assert property (p_fifo_low)
    else $error("fifo state not 01 below half");

  property p_fifo_ovf;
    @(posedge clk) disable iff (!rst_n)
      (fifo_ev.wr_attempt && fifo_ev.full) |=>
        fifo_state_ff == 2'h2 [*1] ##1
        (fifo_state_ff == 2'h2 || $past(rd_fifo) ||
         $past(udf_ev) || $past(ovf_ev));
  endproperty
  a_fifo_ovf: assert property (p_fifo_ovf)
    else $error("overflow code 10 not reported");

  property p_fifo_udf;
    @(posedge clk) disable iff (!rst_n)
      (fifo_ev.ran_empty && !ovf_ev) |=>
        (fifo_state_ff == 2'h3) ==
        !$past(fifo_ev.end_of_message_flag) ||
        $past(fifo_err_ff) != 2'h0;
  endproperty
  a_fifo_udf: assert property (p_fifo_udf)
    else $error("underflow code wrong for end-of-message");

  property p_fifo_onestep;
    @(posedge clk) disable iff (!rst_n)
      $changed(fifo_state_ff) |->
        fifo_state_ff == $past(nxt_fifo_state);
  endproperty
  a_fifo_onestep: assert property (p_fifo_onestep)
    else $error("fifo state bits split");

  property p_cnt_inhibit;
    @(posedge clk) disable iff (!rst_n)
      (cnt_inhibit && !rd_cnt) |=> $stable(err_count);
  endproperty
  a_cnt_inhibit: assert property (p_cnt_inhibit)
    else $error("counter moved during los or oof");

  property p_cnt_clear;
    @(posedge clk) disable iff (!rst_n)
      (rd_cnt && err_inc == 2'h0) |=> err_count == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("counter not cleared by read");

  property p_cnt_sat;
    @(posedge clk) disable iff (!rst_n)
      (err_count == cnt_max && !rd_cnt && $stable(compat_ff))
        |=> err_count == $past(cnt_max);
  endproperty
  a_cnt_sat: assert property (p_cnt_sat)
    else $error("counter wrapped past maximum");

  property p_cnt_narrow;
    @(posedge clk) disable iff (!rst_n)
      (compat_ff && $past(compat_ff) && $past(rd_cnt)) |->
        err_count[15:8] == 8'h00;
  endproperty
  a_cnt_narrow: assert property (p_cnt_narrow)
    else $error("8-bit counter exceeded a byte");

  property p_cap_hi;
    @(posedge clk) disable iff (!rst_n)
      (rd_cnt && !compat_ff) |=> cap_ff == $past(err_count[15:8]);
  endproperty
  a_cap_hi: assert property (p_cap_hi)
    else $error("high byte not captured on low byte read");

  property p_feac_start;
    @(posedge clk) disable iff (!rst_n)
      feac_go |=> feac_busy;
  endproperty
  a_feac_start: assert property (p_feac_start)
    else $error("start flag write did not start sender");

  property p_feac_done;
    @(posedge clk) disable iff (!rst_n)
      $fell(feac_busy) |-> ##1 (int_sts_ff[IRQ_FEAC_DONE]);
  endproperty
  a_feac_done: assert property (p_feac_done)
    else $error("completion not flagged when bit 7 fell");

  property p_rd_timing;
    @(posedge clk) disable iff (!rst_n)
      (rd_en && sel_feac) |=>
        rd_data[7] == $past(feac_busy);
  endproperty
  a_rd_timing: assert property (p_rd_timing)
    else $error("bit 7 read does not show sender state");

endmodule

/* feac_line_rx.sv */
`timescale 1ns/1ps
// Far-end view of the FEAC channel: offers one bit slot every four clocks
// and frames the serial words it sees
module feac_line_rx (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tx_bit,
  output logic             slot,
  output logic [15:0]      word_cnt,
  output logic [15:0]      last_word
);
  logic [1:0]  div_ff;
  logic [15:0] shift_ff;
  logic [4:0]  bits_ff;
  logic [15:0] nxt_shift;
  logic        take;

  assign slot      = (div_ff == 2'h3);
  assign nxt_shift = {tx_bit, shift_ff[15:1]};
  // A word opens on the first zero after idle ones
  assign take      = slot && ((bits_ff != 5'h00) || !tx_bit);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff    <= 2'h0;
      shift_ff  <= 16'hffff;
      bits_ff   <= 5'h00;
      word_cnt  <= 16'h0000;
      last_word <= 16'h0000;
    end else begin
      div_ff <= div_ff + 2'h1;
      if (take) begin
        shift_ff <= nxt_shift;
        bits_ff  <= (bits_ff == 5'h0f) ? 5'h00 : bits_ff + 5'h01;
        if (bits_ff == 5'h0f) begin
          last_word <= nxt_shift;
          word_cnt  <= word_cnt + 16'h0001;
        end
      end
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import ds3_ovh_pkg::*;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic [5:0]  addr     = 6'h00;
  logic [7:0]  wr_data  = 8'h00;
  logic        wr_en    = 1'b0;
  logic        rd_en    = 1'b0;
  logic [7:0]  rd_data;
  logic        irq;
  tx_fifo_ev_s fifo_ev  = '0;
  line_err_s   line_err = '0;
  logic        compat   = 1'b0;
  logic        slot;
  logic        tx_bit;
  logic [15:0] word_cnt;
  logic [15:0] last_word;
  logic [15:0] n0;
  logic [7:0]  rd_val;
  int          mismatches      = 0;
  int          samples_checked = 0;

  always #2.5 clk = ~clk;

  ds3_overhead_status_regs dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
    .fifo_ev(fifo_ev), .line_err(line_err),
    .legacy_compat_select_pin(compat), .c3_bit_slot(slot),
    .feac_tx_bit(tx_bit)
  );

  feac_line_rx line (
    .clk(clk), .rst_n(rst_n), .tx_bit(tx_bit), .slot(slot),
    .word_cnt(word_cnt), .last_word(last_word)
  );

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  task automatic reg_rd(input logic [5:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    rd_val = rd_data;
  endtask

  task automatic expect_reg(input logic [5:0] a, input logic [7:0] e);
    reg_rd(a);
    cmp({8'h00, rd_val}, {8'h00, e});
  endtask

  task automatic ev_pulse(input logic wa, input logic re);
    @(posedge clk);
    fifo_ev.wr_attempt <= wa;
    fifo_ev.ran_empty  <= re;
    @(posedge clk);
    fifo_ev.wr_attempt <= 1'b0;
    fifo_ev.ran_empty  <= 1'b0;
  endtask

  task automatic err_burst(input int n, input logic [3:0] e);
    @(posedge clk);
    line_err <= e;
    repeat (n) @(posedge clk);
    line_err <= '0;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 1000; i++) begin
      reg_rd(FEAC_TX_OFS);
      if (rd_val[7] === 1'b0) begin
        return;
      end
    end
    mismatches++;
    report_and_stop();
  endtask

  task automatic t_reset();
    expect_reg(TX_FIFO_STATUS_OFS, 8'h02);
    expect_reg(FRAME_ERR_CNT_OFS, 8'h00);
    expect_reg(FEAC_TX_OFS, 8'h00);
    expect_reg(INT_STATUS_OFS, 8'h00);
    expect_reg(6'h05, 8'h00);
    cmp({15'h0, tx_bit}, 16'h0001);
  endtask

  task automatic t_fifo();
    @(posedge clk);
    fifo_ev.half_or_more <= 1'b1;
    fifo_ev.full         <= 1'b1;
    expect_reg(TX_FIFO_STATUS_OFS, 8'h00);
    ev_pulse(1'b1, 1'b0);
    expect_reg(TX_FIFO_STATUS_OFS, 8'h04);
    expect_reg(TX_FIFO_STATUS_OFS, 8'h00);
    @(posedge clk);
    fifo_ev.half_or_more        <= 1'b0;
    fifo_ev.full                <= 1'b0;
    fifo_ev.end_of_message_flag <= 1'b1;
    ev_pulse(1'b0, 1'b1);
    expect_reg(TX_FIFO_STATUS_OFS, 8'h02);
    @(posedge clk);
    fifo_ev.end_of_message_flag <= 1'b0;
    ev_pulse(1'b0, 1'b1);
    expect_reg(TX_FIFO_STATUS_OFS, 8'h06);
    expect_reg(INT_STATUS_OFS, 8'h03);
    reg_wr(INT_ENABLE_OFS, 8'h01);
    repeat (2) @(posedge clk);
    #1 cmp({15'h0, irq}, 16'h0001);
    reg_wr(INT_ENABLE_OFS, 8'h00);
    repeat (2) @(posedge clk);
    #1 cmp({15'h0, irq}, 16'h0000);
    reg_wr(INT_ENABLE_OFS, 8'h03);
    reg_wr(INT_CLEAR_OFS, 8'h03);
    repeat (2) @(posedge clk);
    #1 cmp({15'h0, irq}, 16'h0000);
    expect_reg(INT_STATUS_OFS, 8'h00);
    expect_reg(INT_ENABLE_OFS, 8'h03);
    reg_wr(INT_ENABLE_OFS, 8'h00);
  endtask

  task automatic t_counter();
    err_burst(3, 4'h8);
    err_burst(1, 4'hc);
    err_burst(4, 4'he);
    err_burst(4, 4'hd);
    expect_reg(FRAME_ERR_CNT_OFS, 8'h05);
    expect_reg(FRAME_ERR_CNT_OFS, 8'h00);
    err_burst(300, 4'hc);
    expect_reg(FRAME_ERR_CNT_OFS, 8'h58);
    expect_reg(HIGH_BYTE_CAP_OFS, 8'h02);
    @(posedge clk);
    compat <= 1'b1;
    repeat (3) @(posedge clk);
    reg_wr(INT_CLEAR_OFS, 8'hff);
    err_burst(200, 4'hc);
    expect_reg(FRAME_ERR_CNT_OFS, 8'hff);
    expect_reg(HIGH_BYTE_CAP_OFS, 8'h02);
    expect_reg(INT_STATUS_OFS, 8'h08);
    @(posedge clk);
    compat <= 1'b0;
  endtask

  task automatic t_feac_ten();
    reg_wr(INT_CLEAR_OFS, 8'hff);
    n0 = word_cnt;
    reg_wr(FEAC_TX_OFS, 8'had);
    expect_reg(FEAC_TX_OFS, 8'had);
    reg_wr(FEAC_TX_OFS, 8'h12);
    expect_reg(FEAC_TX_OFS, 8'had);
    wait_idle();
    // Far end frames the last bit one slot after the sender goes idle
    repeat (8) @(posedge clk);
    cmp(word_cnt - n0, 16'h000a);
    cmp(last_word, {8'hff, 1'b0, 6'h2d, 1'b0});
    expect_reg(INT_STATUS_OFS, 8'h04);
    repeat (12) @(posedge clk);
    #1 cmp({15'h0, tx_bit}, 16'h0001);
  endtask

  task automatic t_feac_cont();
    n0 = word_cnt;
    reg_wr(FEAC_TX_OFS, 8'hd5);
    repeat (260) @(posedge clk);
    expect_reg(FEAC_TX_OFS, 8'hd5);
    reg_wr(FEAC_TX_OFS, 8'h80);
    wait_idle();
    repeat (8) @(posedge clk);
    cmp({15'h0, (word_cnt - n0) >= 16'h0004}, 16'h0001);
    cmp(last_word, {8'hff, 1'b0, 6'h15, 1'b0});
    repeat (12) @(posedge clk);
    #1 cmp({15'h0, tx_bit}, 16'h0001);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fifo();
    t_counter();
    t_feac_cont();
    t_feac_ten();
    report_and_stop();
  end
endmodule
